// >>> hw/smk_pkg.sv
// Package with the constants and carrier types of the setup-mode key access block.
package smk_pkg;

  localparam logic [9:0] KEY_PORT_PRI  = 10'h3f0;
  localparam logic [9:0] KEY_PORT_ALT  = 10'h370;
  localparam logic [9:0] DATA_PORT_OFS = 10'h001;
  localparam logic [7:0] UNLOCK_KEY    = 8'h55;
  localparam logic [7:0] LOCK_KEY      = 8'haa;
  localparam logic [5:0] LAST_REG      = 6'h2f;
  localparam int         NUM_REGS      = 48;
  localparam logic [7:0] PTR_RESET     = 8'h00;

  // Default contents of the setup register set, index 0 in the low byte.
  localparam logic [NUM_REGS*8-1:0] REG_DEFAULTS = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3d, 8'h3c, 8'h3c,
    8'h00, 8'h3c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h04, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hff, 8'h00, 8'h00, 8'h78, 8'h88, 8'h9c, 8'h28};

  typedef enum logic [1:0] {
    SMK_LOCKED,
    SMK_ARMED,
    SMK_SETUP
  } smk_state_e;

  // One host I/O cycle as seen on the bus pins.
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } smk_io_s;

endpackage

// >>> hw/smk_setup_access.sv
// Setup register bank with a key port (unlock, lock and pointer) and a data port on the host I/O bus.
module smk_setup_access (
  // Clock, reset and enable
  input  wire logic                         ref_clk_i,
  input  wire logic                         rstn_i,
  input  wire logic                         clk_en_i,
  // Strap pin
  input  wire logic                         address_select_strap_pin_i,
  // Host I/O bus, strobes already in the clock domain, one-cycle pulses
  input  wire smk_pkg::smk_io_s             io_i,
  // Read data, status and register contents
  output logic      [7:0]                   rdata_o,
  output logic                              rdata_valid_o,
  output logic                              setup_mode_o,
  output logic      [smk_pkg::NUM_REGS*8-1:0] setup_regs_o
);

  logic                        strap_s1_q;
  logic                        strap_s2_q;
  logic                        in_reset_q;
  logic                        address_select_strap_q;
  logic                        address_select_strap_d;
  smk_pkg::smk_state_e         state_q;
  smk_pkg::smk_state_e         state_d;
  logic [7:0]                  ptr_q;
  logic [7:0]                  ptr_d;
  logic [smk_pkg::NUM_REGS*8-1:0] regs_q;
  logic [smk_pkg::NUM_REGS*8-1:0] regs_d;
  logic [7:0]                  rdata_d;
  logic                        rvalid_d;
  logic [9:0]                  key_addr;
  logic                        hit_key;
  logic                        hit_data;
  logic                        ptr_ok;

  // Strap pin passes two flip-flops, then is held in address_select_strap_q from the first enabled clock after reset.
  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i) begin
      strap_s1_q <= address_select_strap_pin_i;
      strap_s2_q <= strap_s1_q;
    end
  end

  always_comb begin
    address_select_strap_d = address_select_strap_q;
    if (in_reset_q) begin
      address_select_strap_d = strap_s2_q;
    end
  end

  assign key_addr = address_select_strap_q ? smk_pkg::KEY_PORT_ALT
                                           : smk_pkg::KEY_PORT_PRI;
  assign hit_key  = io_i.addr == key_addr;
  assign hit_data = io_i.addr == key_addr + smk_pkg::DATA_PORT_OFS;
  assign ptr_ok   = ptr_q <= {2'b00, smk_pkg::LAST_REG};

  always_comb begin
    state_d  = state_q;
    ptr_d    = ptr_q;
    regs_d   = regs_q;
    rdata_d  = rdata_o;
    rvalid_d = 1'b0;
    case (state_q)
      smk_pkg::SMK_LOCKED: begin
        if (io_i.wr && hit_key && io_i.wdata == smk_pkg::UNLOCK_KEY) begin
          state_d = smk_pkg::SMK_ARMED;
        end
      end
      smk_pkg::SMK_ARMED: begin
        if (io_i.wr) begin
          if (hit_key && io_i.wdata == smk_pkg::UNLOCK_KEY) begin
            state_d = smk_pkg::SMK_SETUP;
          end else begin
            state_d = smk_pkg::SMK_LOCKED;
          end
        end
      end
      smk_pkg::SMK_SETUP: begin
        if (io_i.wr && hit_key) begin
          if (io_i.wdata == smk_pkg::LOCK_KEY) begin
            state_d = smk_pkg::SMK_LOCKED;
          end else begin
            ptr_d = io_i.wdata;
          end
        end else if (io_i.wr && hit_data && ptr_ok) begin
          regs_d[ptr_q[5:0]*8 +: 8] = io_i.wdata;
        end else if (io_i.rd && hit_data) begin
          rvalid_d = 1'b1;
          rdata_d  = ptr_ok ? regs_q[ptr_q[5:0]*8 +: 8] : 8'h00;
        end
      end
      default: begin
        state_d = smk_pkg::SMK_LOCKED;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      in_reset_q             <= 1'b1;
      address_select_strap_q <= 1'b0;
      state_q                <= smk_pkg::SMK_LOCKED;
      ptr_q                  <= smk_pkg::PTR_RESET;
      regs_q                 <= smk_pkg::REG_DEFAULTS;
      rdata_o                <= 8'h00;
      rdata_valid_o          <= 1'b0;
    end else if (clk_en_i) begin
      in_reset_q             <= 1'b0;
      address_select_strap_q <= address_select_strap_d;
      state_q                <= state_d;
      ptr_q                  <= ptr_d;
      regs_q                 <= regs_d;
      rdata_o                <= rdata_d;
      rdata_valid_o          <= rvalid_d;
    end
  end

  assign setup_mode_o = state_q == smk_pkg::SMK_SETUP;
  assign setup_regs_o = regs_q;

endmodule

// >>> tb/smk_host_model.sv
// Host model issuing one I/O bus cycle per clock.
module smk_host_model (
  // Clock and host bus
  input  wire logic        clk_i,
  output smk_pkg::smk_io_s io_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial io_o = '0;
  // Key writes go out back to back, with nothing between them.
  task automatic op(input logic [9:0] a, input logic [7:0] d, input logic w, input logic r);
    @(posedge clk_i);
    io_o <= '{a, d, w, r};
  endtask
endmodule

// >>> tb/smk_setup_access_monitor.sv
// Port checker of the setup-mode key access block, and its bind.
module smk_setup_access_monitor (
  // Watched ports
  input wire logic             ref_clk_i,
  input wire logic             rstn_i,
  input wire logic             clk_en_i,
  input wire logic             address_select_strap_pin_i,
  input wire smk_pkg::smk_io_s io_i,
  input wire logic             rdata_valid_o,
  input wire logic             setup_mode_o,
  input wire logic [383:0]     setup_regs_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sel_q;
  wire [9:0] key_w = sel_q ? smk_pkg::KEY_PORT_ALT : smk_pkg::KEY_PORT_PRI;
  wire kw_w = clk_en_i && io_i.wr && io_i.addr == key_w;
  wire k55_w = kw_w && io_i.wdata == smk_pkg::UNLOCK_KEY;
  wire dr_w = clk_en_i && io_i.rd && io_i.addr == key_w + 10'h001;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  always_ff @(posedge ref_clk_i) if (!rstn_i) sel_q <= address_select_strap_pin_i;
  rd_locked_a: assert property (dr_w && !setup_mode_o |=> !rdata_valid_o)
    else $error("read answered");
  rd_pulse_a: assert property (dr_w && setup_mode_o |=> rdata_valid_o)
    else $error("read lost");
  vld_cause_a: assert property (rdata_valid_o && $past(clk_en_i) |-> $past(dr_w && setup_mode_o))
    else $error("stray pulse");
  unlock_a: assert property (k55_w && !setup_mode_o ##1 k55_w |=> setup_mode_o)
    else $error("no unlock");
  enter_cause_a: assert property ($rose(setup_mode_o) |-> $past(k55_w))
    else $error("bad unlock");
  cancel_a: assert property (!setup_mode_o && clk_en_i && io_i.wr && !k55_w |=> !setup_mode_o)
    else $error("not cancelled");
  lock_a: assert property (kw_w && io_i.wdata == smk_pkg::LOCK_KEY |=> !setup_mode_o)
    else $error("no lock");
  reset_a: assert property (disable iff (1'b0) !rstn_i && clk_en_i |=> !setup_mode_o
    && setup_regs_o == smk_pkg::REG_DEFAULTS) else $error("bad reset");
  cover property ($rose(setup_mode_o));
  cover property ($fell(setup_mode_o));
  cover property (rdata_valid_o);
endmodule

bind smk_setup_access smk_setup_access_monitor mon_u (.*);

// >>> tb/tb_top.sv
// Bench of the setup-mode key access block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [9:0] a; logic [7:0] d; logic [3:0] f; logic [7:0] e;} smk_row_s;
  localparam logic [9:0] KA = 10'h3f0;
  localparam logic [9:0] DA = 10'h3f1;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic pin = 1'b0;
  logic vld, smode;
  logic [7:0] rdata;
  logic [383:0] regs;
  smk_pkg::smk_io_s io;
  int miscompares = 0, n_checks = 0, cyc = 0;
  // Cycle on the bus, then flags write, read, setup, valid and the read data seen meanwhile.
  smk_row_s rows [13] = '{'{DA, 8'h00, 4'h4, 8'h00}, '{KA, 8'h55, 4'h8, 8'h00},
    '{10'h3f2, 8'h00, 4'h8, 8'h00}, '{KA, 8'h55, 4'h8, 8'h00}, '{KA, 8'h55, 4'h8, 8'h00},
    '{KA, 8'h2f, 4'ha, 8'h00}, '{DA, 8'ha5, 4'ha, 8'h00}, '{DA, 8'h00, 4'h6, 8'h00},
    '{KA, 8'h00, 4'hb, 8'ha5}, '{DA, 8'h00, 4'h6, 8'ha5}, '{KA, 8'haa, 4'hb, 8'h28},
    '{DA, 8'h00, 4'h4, 8'h28}, '{10'h00e, 8'hff, 4'h0, 8'h28}};
  smk_host_model host_u (.clk_i(ref_clk_i), .io_o(io));
  smk_setup_access dut_u (.ref_clk_i, .rstn_i, .clk_en_i(1'b1), .address_select_strap_pin_i(pin),
    .io_i(io), .rdata_o(rdata), .rdata_valid_o(vld), .setup_mode_o(smode), .setup_regs_o(regs));
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  task automatic end_sim();
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 500) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input logic ok);
    n_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("wrong value at %0t: output differs", $time);
    end
  endtask
  task automatic rst(input logic s);
    @(posedge ref_clk_i);
    pin <= s;
    rstn_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1 chk(regs === smk_pkg::REG_DEFAULTS && smode === 1'b0);
  endtask
  initial begin
    rst(1'b0);
    foreach (rows[i]) begin
      host_u.op(rows[i].a, rows[i].d, rows[i].f[3], rows[i].f[2]);
      #1 chk({smode, vld, rdata} === {rows[i].f[1:0], rows[i].e});
    end
    chk(regs[383:376] === 8'ha5);
    rst(1'b1);
    for (int j = 0; j < 4; j++) host_u.op(j < 2 ? KA : 10'h370, 8'h55, 1'b1, 1'b0);
    host_u.op(10'h371, 8'h00, 1'b0, 1'b1);
    host_u.op(10'h08e, 8'hff, 1'b0, 1'b0);
    #1 chk({smode, vld, rdata} === {2'b11, 8'h28});
    rst(1'b0);
    end_sim();
  end
endmodule
